// ===== btc_map.svh
// Widths, field codes and counts for the basic timer counter
`ifndef BTC_MAP_SVH
`define BTC_MAP_SVH
`define BTC_CNT_W 16
`define BTC_PSC_W 16
`define BTC_FLT_CFG_W 3
`define BTC_FLT_DIV_W 4
`define BTC_FLT_RUN_W 4
`define BTC_CNT_ZERO 16'h0000
`define BTC_PSC_ONE 16'h0001
`define BTC_FLT_BYPASS 3'h0
`define BTC_FLT_C1 3'h1
`define BTC_FLT_C2 3'h2
`define BTC_FLT_C3 3'h3
`define BTC_FLT_C4 3'h4
`define BTC_FLT_C5 3'h5
`define BTC_FLT_C6 3'h6
`define BTC_FLT_C7 3'h7
`define BTC_FLT_DIV1_M1 4'h0
`define BTC_FLT_DIV4_M1 4'h3
`define BTC_FLT_DIV8_M1 4'h7
`define BTC_FLT_DIV16_M1 4'hf
`define BTC_FLT_N1 4'h1
`define BTC_FLT_N2 4'h2
`define BTC_FLT_N4 4'h4
`define BTC_FLT_N6 4'h6
`define BTC_FLT_N8 4'h8
`endif

// ===== btc_pkg.sv
// Types shared by the basic timer counter modules
package btc_pkg;
  typedef enum logic [1:0] {
    BTC_MODE_TIMER,
    BTC_MODE_COUNTER,
    BTC_MODE_TRIG_START,
    BTC_MODE_GATED
  } btc_mode_t;
endpackage

// ===== btc_flt_if.sv
// Link between the timer core and the trigger input filter
`timescale 1ns/100ps
`include "btc_map.svh"
interface btc_flt_if;
  logic [`BTC_FLT_CFG_W-1:0] cfg;
  logic raw;
  logic level;
  modport core (output cfg, output raw, input level);
  modport filt (input cfg, input raw, output level);
endinterface

// ===== btc_filter.sv
// Noise filter for the synchronised external trigger input
`timescale 1ns/100ps
`include "btc_map.svh"
module btc_filter (
  input wire logic clk_sys,
  input wire logic rst,
  btc_flt_if.filt flt
);
  import btc_pkg::*;

  function automatic logic [`BTC_FLT_DIV_W-1:0] flt_div_m1(input logic [`BTC_FLT_CFG_W-1:0] c);
    unique case (c)
      `BTC_FLT_C4, `BTC_FLT_C5: flt_div_m1 = `BTC_FLT_DIV4_M1;
      `BTC_FLT_C6: flt_div_m1 = `BTC_FLT_DIV8_M1;
      `BTC_FLT_C7: flt_div_m1 = `BTC_FLT_DIV16_M1;
      default: flt_div_m1 = `BTC_FLT_DIV1_M1;
    endcase
  endfunction

  function automatic logic [`BTC_FLT_RUN_W-1:0] flt_need(input logic [`BTC_FLT_CFG_W-1:0] c);
    unique case (c)
      `BTC_FLT_BYPASS: flt_need = `BTC_FLT_N1;
      `BTC_FLT_C1: flt_need = `BTC_FLT_N2;
      `BTC_FLT_C2, `BTC_FLT_C4: flt_need = `BTC_FLT_N4;
      `BTC_FLT_C3, `BTC_FLT_C5, `BTC_FLT_C6: flt_need = `BTC_FLT_N6;
      default: flt_need = `BTC_FLT_N8;
    endcase
  endfunction

  logic [`BTC_FLT_DIV_W-1:0] div_q;
  logic [`BTC_FLT_RUN_W-1:0] run_q;
  logic [`BTC_FLT_RUN_W-1:0] run_d;
  logic last_q;
  logic level_q;
  logic smp;

  // Sample strobe from the system clock or a division of it
  assign smp = (div_q == flt_div_m1(flt.cfg));

  always_ff @(posedge clk_sys)
  begin
    if (rst || smp)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  always_comb
  begin
    if (flt.raw != last_q)
      run_d = `BTC_FLT_N1;
    else if (run_q == `BTC_FLT_N8)
      run_d = run_q;
    else
      run_d = run_q + 1'b1;
  end

  // Level only moves after N equal samples in a row
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      run_q <= '0;
      last_q <= 1'b0;
      level_q <= 1'b0;
    end
    else if (smp)
    begin
      run_q <= run_d;
      last_q <= flt.raw;
      if (run_d >= flt_need(flt.cfg))
        level_q <= flt.raw;
    end
  end

  assign flt.level = level_q;
endmodule // btc_filter

// ===== btc_timer.sv
// Basic timer counter core: prescaler, 16-bit up counter, trigger and toggle logic
`timescale 1ns/100ps
`include "btc_map.svh"
module btc_timer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ext_trigger_in,
  input wire logic cascade_trigger_in,
  input wire btc_pkg::btc_mode_t mode_sel,
  input wire logic trigger_source_sel,
  input wire logic input_polarity_sel,
  input wire logic [`BTC_FLT_CFG_W-1:0] input_filter_cfg,
  input wire logic single_run_sel,
  input wire logic toggle_out_enable,
  input wire logic [`BTC_PSC_W-1:0] prescale_value,
  input wire logic [`BTC_CNT_W-1:0] reload_value,
  input wire logic enable_wr,
  input wire logic enable_wdata,
  input wire logic ov_irq_enable,
  input wire logic trig_irq_enable,
  input wire logic ov_flag_clear,
  input wire logic trig_flag_clear,
  output logic enable_status,
  output logic [`BTC_CNT_W-1:0] count_value,
  output logic overflow_pulse,
  output logic ov_flag,
  output logic trigger_event_flag,
  output logic ov_irq,
  output logic trig_irq,
  output logic ov_dma_req,
  output logic trig_dma_req,
  output logic toggle_out_pos,
  output logic toggle_out_neg
);
  import btc_pkg::*;

  btc_flt_if flt ();

  logic ext_meta_q;
  logic ext_sync_q;
  logic src_q;
  logic src_prev_q;
  logic rise;
  logic fall;
  logic trig_edge;
  logic gate_on;
  logic en_q;
  logic en_d;
  logic en_rise;
  logic run;
  logic psc_load;
  logic [`BTC_PSC_W-1:0] psc_act_q;
  logic [`BTC_PSC_W-1:0] div_m1;
  logic [`BTC_PSC_W-1:0] psc_cnt_q;
  logic pre_in;
  logic tick;
  logic [`BTC_CNT_W-1:0] cnt_q;
  logic ovp_q;
  logic wrap;
  logic shot_end;
  logic ov_set;
  logic trig_set;
  logic ov_flag_q;
  logic trig_flag_q;
  logic ov_irq_q;
  logic trig_irq_q;
  logic ov_dma_q;
  logic trig_dma_q;
  logic tog_en_q;
  logic tog_pos_q;
  logic tog_neg_q;

  // Pin input crosses in through two flops; first flop feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end
    else
    begin
      ext_meta_q <= ext_trigger_in;
      ext_sync_q <= ext_meta_q;
    end
  end

  assign flt.cfg = input_filter_cfg;
  assign flt.raw = ext_sync_q;

  btc_filter u_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .flt(flt)
  );

  // Cascade input shares this clock so it needs no synchroniser
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      src_q <= 1'b0;
      src_prev_q <= 1'b0;
    end
    else
    begin
      src_q <= trigger_source_sel ? cascade_trigger_in : flt.level;
      src_prev_q <= src_q;
    end
  end

  assign rise = src_q & ~src_prev_q;
  assign fall = ~src_q & src_prev_q;
  assign trig_edge = input_polarity_sel ? fall : rise;
  // Gate always looks at the filtered pin, never the cascade input
  assign gate_on = flt.level ^ input_polarity_sel;

  assign en_rise = en_d & ~en_q;
  // Hold the counter in the cycle a single run is finishing
  assign shot_end = ovp_q & single_run_sel;
  assign run = en_q & ~shot_end;

  // Enable: software write first, then hardware set by a trigger, then single-run clear
  always_comb
  begin
    if (enable_wr)
      en_d = enable_wdata;
    else if (mode_sel == BTC_MODE_TRIG_START && trig_edge)
      en_d = 1'b1;
    else if (shot_end)
      en_d = 1'b0;
    else
      en_d = en_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      en_q <= 1'b0;
    else
      en_q <= en_d;
  end

  // Adopt on the wrap edge itself so a period never gains an extra cycle
  assign psc_load = en_rise | wrap;

  // Pending prescale value is only adopted at overflow or enable rising
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      psc_act_q <= '0;
    else if (psc_load)
      psc_act_q <= prescale_value;
  end

  // Divide-by minus one: value for the clock source, value minus one for events
  always_comb
  begin
    if (mode_sel != BTC_MODE_COUNTER)
      div_m1 = psc_act_q;
    else if (psc_act_q == '0)
      div_m1 = '0;
    else
      div_m1 = psc_act_q - `BTC_PSC_ONE;
  end

  always_comb
  begin
    unique case (mode_sel)
      BTC_MODE_COUNTER: pre_in = trig_edge;
      BTC_MODE_GATED: pre_in = gate_on;
      default: pre_in = 1'b1;
    endcase
  end

  assign tick = run && pre_in && (psc_cnt_q == div_m1);

  always_ff @(posedge clk_sys)
  begin
    if (rst || psc_load)
      psc_cnt_q <= '0;
    else if (run && pre_in)
    begin
      if (psc_cnt_q == div_m1)
        psc_cnt_q <= '0;
      else
        psc_cnt_q <= psc_cnt_q + `BTC_PSC_ONE;
    end
  end

  assign wrap = tick && (cnt_q == reload_value);

  // Reload lowered under the count restarts from zero with no overflow
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_q <= `BTC_CNT_ZERO;
    else if (en_q && cnt_q > reload_value)
      cnt_q <= `BTC_CNT_ZERO;
    else if (wrap)
      cnt_q <= `BTC_CNT_ZERO;
    else if (tick)
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ovp_q <= 1'b0;
    else
      ovp_q <= wrap && !(cnt_q > reload_value);
  end

  assign ov_set = shot_end | (wrap & ~single_run_sel);
  assign trig_set = trig_edge && (mode_sel == BTC_MODE_TRIG_START || mode_sel == BTC_MODE_COUNTER);

  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ov_flag_q <= 1'b0;
    else if (ov_set)
      ov_flag_q <= 1'b1;
    else if (ov_flag_clear)
      ov_flag_q <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      trig_flag_q <= 1'b0;
    else if (trig_set)
      trig_flag_q <= 1'b1;
    else if (trig_flag_clear)
      trig_flag_q <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ov_irq_q <= 1'b0;
    else
      ov_irq_q <= ov_flag_q & ov_irq_enable;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      trig_irq_q <= 1'b0;
    else
      trig_irq_q <= trig_flag_q & trig_irq_enable;
  end

  // DMA requests are one-cycle pulses, one per event
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ov_dma_q <= 1'b0;
    else
      ov_dma_q <= ov_set;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      trig_dma_q <= 1'b0;
    else
      trig_dma_q <= trig_set;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tog_en_q <= 1'b0;
    else
      tog_en_q <= toggle_out_enable;
  end

  // Toggle pair restarts high/low each time it is enabled
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tog_pos_q <= 1'b0;
      tog_neg_q <= 1'b0;
    end
    else
    begin
      if (!toggle_out_enable)
      begin
        tog_pos_q <= 1'b0;
        tog_neg_q <= 1'b0;
      end
      else if (!tog_en_q)
      begin
        tog_pos_q <= 1'b1;
        tog_neg_q <= 1'b0;
      end
      else if (ovp_q)
      begin
        tog_pos_q <= ~tog_pos_q;
        tog_neg_q <= ~tog_neg_q;
      end
    end
  end

  assign enable_status = en_q;
  assign count_value = cnt_q;
  assign overflow_pulse = ovp_q;
  assign ov_flag = ov_flag_q;
  assign trigger_event_flag = trig_flag_q;
  assign ov_irq = ov_irq_q;
  assign trig_irq = trig_irq_q;
  assign ov_dma_req = ov_dma_q;
  assign trig_dma_req = trig_dma_q;
  assign toggle_out_pos = tog_pos_q;
  assign toggle_out_neg = tog_neg_q;
endmodule // btc_timer

// ===== btc_chk.sv
// Port assertions for the basic timer counter
`timescale 1ns/100ps
`include "btc_map.svh"
module btc_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic single_run_sel,
  input wire logic enable_wr,
  input wire logic ov_irq_enable,
  input wire logic ov_flag_clear,
  input wire logic toggle_out_enable,
  input wire logic enable_status,
  input wire logic [`BTC_CNT_W-1:0] count_value,
  input wire logic overflow_pulse,
  input wire logic ov_flag,
  input wire logic ov_irq,
  input wire logic ov_dma_req,
  input wire logic toggle_out_pos,
  input wire logic toggle_out_neg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_pulse;
    overflow_pulse ##1 !overflow_pulse;
  endsequence
  // Enable write wins over the hardware clear, so it is left out
  sequence s_stop;
    ##1 ov_flag && !enable_status && ov_dma_req;
  endsequence
  chk_pulse_one: assert property (overflow_pulse |-> s_pulse)
    else $error("overflow pulse longer than one cycle");
  chk_wrap_zero: assert property (overflow_pulse |-> count_value == `BTC_CNT_ZERO)
    else $error("count not zero at overflow");
  chk_single_stop: assert property (overflow_pulse && single_run_sel && !enable_wr |-> s_stop)
    else $error("single run did not stop");
  chk_dma_cont: assert property (overflow_pulse && !single_run_sel |-> ov_dma_req && ov_flag)
    else $error("no flag or dma with overflow");
  chk_irq_follow: assert property (ov_irq == $past(ov_flag && ov_irq_enable))
    else $error("overflow irq does not follow flag");
  chk_flag_hold: assert property (ov_flag && !ov_flag_clear |=> ov_flag)
    else $error("overflow flag dropped");
  chk_tog_comp: assert property (toggle_out_enable ##1 toggle_out_enable |-> toggle_out_pos != toggle_out_neg)
    else $error("toggle outputs not complementary");
  chk_tog_flip: assert property (overflow_pulse && toggle_out_enable && $past(toggle_out_enable)
    |=> toggle_out_pos == !$past(toggle_out_pos))
    else $error("toggle did not flip");
  chk_count_step: assert property (count_value != $past(count_value)
    |-> count_value == $past(count_value) + 1'b1 || count_value == `BTC_CNT_ZERO)
    else $error("count jumped");
endmodule // btc_chk
bind btc_timer btc_chk u_chk (.clk_sys, .rst, .single_run_sel, .enable_wr, .ov_irq_enable, .ov_flag_clear,
  .toggle_out_enable, .enable_status, .count_value, .overflow_pulse, .ov_flag, .ov_irq, .ov_dma_req,
  .toggle_out_pos, .toggle_out_neg);

// ===== btc_pin_src.sv
// Model of the source driving the external trigger pin
`timescale 1ns/100ps
module btc_pin_src (
  input wire logic clk_sys,
  output logic ext_trigger_in
);
  initial ext_trigger_in = 1'b0;
  // Pin moves just after an edge, then holds for n cycles
  task automatic hold(input logic lvl, input int n);
    @(posedge clk_sys);
    #2 ext_trigger_in = lvl;
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
endmodule // btc_pin_src

// ===== btc_timer_tb.sv
// Self-checking bench for the basic timer counter
`timescale 1ns/100ps
`include "btc_map.svh"
`define CHK(s, e, a) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", s, e, a); end end
module btc_timer_tb;
  import btc_pkg::*;
  logic clk_sys, rst, cascade_trigger_in, trigger_source_sel, input_polarity_sel, single_run_sel;
  logic toggle_out_enable, enable_wr, enable_wdata, ov_irq_enable, trig_irq_enable, ov_flag_clear;
  logic trig_flag_clear, enable_status, overflow_pulse, ov_flag, trigger_event_flag, ov_irq, trig_irq;
  logic ov_dma_req, trig_dma_req, toggle_out_pos, toggle_out_neg, ext_trigger_in, p;
  btc_mode_t mode_sel;
  logic [`BTC_FLT_CFG_W-1:0] input_filter_cfg;
  logic [`BTC_PSC_W-1:0] prescale_value;
  logic [`BTC_CNT_W-1:0] reload_value, count_value, seen;
  int error_cnt, samples_checked, n;
  btc_timer uut (.clk_sys, .rst, .ext_trigger_in, .cascade_trigger_in, .mode_sel, .trigger_source_sel,
    .input_polarity_sel, .input_filter_cfg, .single_run_sel, .toggle_out_enable, .prescale_value,
    .reload_value, .enable_wr, .enable_wdata, .ov_irq_enable, .trig_irq_enable, .ov_flag_clear,
    .trig_flag_clear, .enable_status, .count_value, .overflow_pulse, .ov_flag, .trigger_event_flag,
    .ov_irq, .trig_irq, .ov_dma_req, .trig_dma_req, .toggle_out_pos, .toggle_out_neg);
  btc_pin_src ext (.clk_sys, .ext_trigger_in);
  task automatic tick(input int k = 1);
    repeat (k) @(posedge clk_sys);
    #2 n += k;
  endtask
  task automatic set_en(input logic v);
    enable_wr = 1'b1;
    enable_wdata = v;
    tick();
    enable_wr = 1'b0;
  endtask
  task automatic gap(input int lim);
    n = 0;
    tick();
    while (overflow_pulse !== 1'b1 && n < lim) tick();
  endtask
  task automatic clr();
    ov_flag_clear = 1'b1;
    trig_flag_clear = 1'b1;
    tick();
    ov_flag_clear = 1'b0;
    trig_flag_clear = 1'b0;
  endtask
  task automatic t_single();
    single_run_sel = 1'b1;
    reload_value = 16'h0002;
    set_en(1'b1);
    tick(2);
    `CHK("count", 16'h0002, count_value)
    tick();
    `CHK("wrap", 17'h10000, {overflow_pulse, count_value})
    tick();
    `CHK("stop", 4'h5, {overflow_pulse, ov_flag, enable_status, ov_dma_req})
    tick();
    `CHK("irq", 1'b1, ov_irq)
    clr();
    tick();
    `CHK("clear", 2'h0, {ov_flag, ov_irq})
    prescale_value = 16'hffff;
    reload_value = 16'h0000;
    set_en(1'b1);
    gap(70000);
    `CHK("div max", 32'd65536, n)
    tick();
    clr();
    `CHK("ov clear", 1'b0, ov_flag)
  endtask
  task automatic t_period();
    single_run_sel = 1'b0;
    toggle_out_enable = 1'b1;
    prescale_value = 16'h0003;
    reload_value = 16'h0004;
    set_en(1'b1);
    gap(100);
    `CHK("first", 32'd20, n)
    p = toggle_out_pos;
    prescale_value = 16'h0001;
    gap(100);
    `CHK("pending", 32'd20, n)
    `CHK("toggle", {!p, p}, {toggle_out_pos, toggle_out_neg})
    gap(100);
    `CHK("adopted", 32'd10, n)
    reload_value = 16'h0040;
    for (int i = 0; i < 100 && count_value !== 16'h000a; i++) tick();
    reload_value = 16'h0003;
    repeat (3)
    begin
      tick();
      `CHK("no pulse", 1'b0, overflow_pulse)
    end
    `CHK("restart", 1'b1, count_value < 16'h0003)
    set_en(1'b0);
    toggle_out_enable = 1'b0;
    clr();
    `CHK("toggle off", 2'h0, {toggle_out_pos, toggle_out_neg})
  endtask
  task automatic t_trig();
    mode_sel = BTC_MODE_TRIG_START;
    single_run_sel = 1'b1;
    reload_value = 16'h0100;
    trigger_source_sel = 1'b1;
    cascade_trigger_in = 1'b1;
    for (int i = 0; i < 10 && trigger_event_flag !== 1'b1; i++) tick();
    `CHK("cascade", 3'h7, {enable_status, trigger_event_flag, trig_dma_req})
    tick();
    `CHK("trig irq", 1'b1, trig_irq)
    cascade_trigger_in = 1'b0;
    set_en(1'b0);
    clr();
    trigger_source_sel = 1'b0;
    input_polarity_sel = 1'b1;
    input_filter_cfg = `BTC_FLT_C5;
    ext.hold(1'b1, 40);
    ext.hold(1'b0, 12);
    ext.hold(1'b1, 40);
    `CHK("no trig", 1'b0, enable_status)
    ext.hold(1'b0, 40);
    `CHK("pin trig", 2'h3, {enable_status, trigger_event_flag})
    set_en(1'b0);
    clr();
  endtask
  task automatic t_gate();
    mode_sel = BTC_MODE_GATED;
    input_polarity_sel = 1'b0;
    input_filter_cfg = `BTC_FLT_BYPASS;
    single_run_sel = 1'b0;
    reload_value = 16'hffff;
    set_en(1'b1);
    tick(6);
    seen = count_value;
    tick(8);
    `CHK("gate off", seen, count_value)
    ext.hold(1'b1, 10);
    `CHK("gate on", 1'b1, count_value > seen)
    input_polarity_sel = 1'b1;
    tick(6);
    seen = count_value;
    tick(8);
    `CHK("gate low", seen, count_value)
    set_en(1'b0);
  endtask
  task automatic t_counter();
    mode_sel = BTC_MODE_COUNTER;
    trigger_source_sel = 1'b1;
    prescale_value = 16'h0002;
    tick(2);
    set_en(1'b1);
    seen = count_value;
    repeat (4)
    begin
      cascade_trigger_in = 1'b1;
      tick(2);
      cascade_trigger_in = 1'b0;
      tick(2);
    end
    `CHK("counted", seen + 16'h0002, count_value)
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial
  begin
    {rst, cascade_trigger_in, trigger_source_sel, input_polarity_sel, single_run_sel} = 5'h10;
    {toggle_out_enable, enable_wr, enable_wdata, ov_flag_clear, trig_flag_clear} = 5'h00;
    {ov_irq_enable, trig_irq_enable} = 2'h3;
    mode_sel = BTC_MODE_TIMER;
    input_filter_cfg = `BTC_FLT_BYPASS;
    prescale_value = `BTC_PSC_W'h0;
    reload_value = `BTC_CNT_ZERO;
    tick(4);
    rst = 1'b0;
    t_single();
    t_period();
    t_trig();
    t_gate();
    t_counter();
    conclude();
  end
  // Longest scenario is the full-ratio divide, about 1.3 ms
  initial
  begin
    #3000000;
    error_cnt++;
    conclude();
  end
endmodule // btc_timer_tb
